/* fault_log_pkg.sv */
// Constants, carrier types and state codes shared by the fault and peak logger
package fault_log_pkg;
   localparam int RAILS_DEF = 10;
   localparam int FAULTS_DEF = 8;
   localparam int VOLT_W = 12;
   localparam int RAIL_W = 4;
   localparam int KIND_W = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int DAYS_KEEP_W = 12;
   // Timing: 50 MHz clock, one millisecond tick drives the run-time clock
   localparam int CLK_HZ = 50_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
   localparam int PEAK_HOLD_S = 30;
   localparam int PEAK_HOLD_MS_DEF = PEAK_HOLD_S * MS_PER_S;
   localparam logic [31:0] MS_PER_DAY = 32'h0526_5c00;
   // Supply comparator threshold, in millivolts, for reference only
   localparam int BROWNOUT_MV = 2900;
   // Flash word map
   localparam logic [ADDR_W-1:0] NVM_RESETS = 8'h00;
   localparam logic [ADDR_W-1:0] NVM_RTC_MS = 8'h01;
   localparam logic [ADDR_W-1:0] NVM_RTC_DAYS = 8'h02;
   localparam logic [ADDR_W-1:0] NVM_PEAK_BASE = 8'h04;
   localparam logic [ADDR_W-1:0] NVM_FAULT_BASE = 8'h20;
   localparam int NVM_PEAK_ROOM = 28;
   localparam int NVM_FAULT_ROOM = 112;
   // Values after reset
   localparam logic [DATA_W-1:0] RESET_CNT_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RTC_RST = 32'h0000_0000;
   localparam logic [VOLT_W-1:0] PEAK_RST = 12'h000;

   typedef struct packed {
      logic [RAIL_W-1:0] rail;
      logic [KIND_W-1:0] kind;
      logic [VOLT_W-1:0] volt;
      logic [DAYS_KEEP_W-1:0] days;
      logic [DATA_W-1:0] ms;
   } fault_entry_s;

   typedef struct packed {
      logic req;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } nvm_wr_s;

   typedef enum {ENG_IDLE, ENG_FETCH, ENG_FLT, ENG_WAIT} eng_e;
endpackage

/* fault_log_ram.sv */
// Fault entry SRAM: one write port, two registered read ports
`timescale 1ns/1ps
module fault_log_ram
   import fault_log_pkg::*;
#(
   parameter int DEPTH = FAULTS_DEF,
   parameter int AW = $clog2(FAULTS_DEF)
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic we_in,
   input wire logic [AW-1:0] waddr_in,
   input wire fault_entry_s wdata_in,
   input wire logic [AW-1:0] raddr_a_in,
   output fault_entry_s rdata_a_out,
   input wire logic [AW-1:0] raddr_b_in,
   output fault_entry_s rdata_b_out
);
   generate
      if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_depth
         $error("DEPTH does not fit the address width");
      end
   endgenerate

   fault_entry_s mem_q [DEPTH];

   always_ff @(posedge mclk_in) begin
      if (we_in) begin
         mem_q[waddr_in] <= wdata_in;
      end
   end

   // Read ports see the old word on a same-cycle write
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         rdata_a_out <= '0;
         rdata_b_out <= '0;
      end else begin
         rdata_a_out <= mem_q[raddr_a_in];
         rdata_b_out <= mem_q[raddr_b_in];
      end
   end
endmodule

/* run_time_clock.sv */
// Run-time clock: millisecond and day counts with host or restore load
`timescale 1ns/1ps
module run_time_clock
   import fault_log_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic load_in,
   input wire logic [DATA_W-1:0] load_ms_in,
   input wire logic [DATA_W-1:0] load_days_in,
   output logic [DATA_W-1:0] ms_out,
   output logic [DATA_W-1:0] days_out,
   output logic tick_out
);
   generate
      if (MS_CYCLES < 10) begin : g_bad_div
         $error("MS_CYCLES must be at least 10");
      end
   endgenerate

   logic [31:0] div_q;
   wire div_wrap = div_q == 32'(MS_CYCLES - 1);
   wire day_wrap = ms_out == MS_PER_DAY - 32'h1;

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         div_q <= '0;
         tick_out <= 1'b0;
      end else begin
         div_q <= div_wrap ? '0 : div_q + 32'h1;
         tick_out <= div_wrap;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         ms_out <= RTC_RST;
         days_out <= RTC_RST;
      end else if (load_in) begin
         ms_out <= load_ms_in; // [RULE_09]
         days_out <= load_days_in;
      end else if (div_wrap) begin
         ms_out <= day_wrap ? '0 : ms_out + 32'h1; // [RULE_13]
         days_out <= day_wrap ? days_out + 32'h1 : days_out;
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   // Reset release edge still samples reset state, so skip loads seen there
   rtc_load_a: assert property (load_in && !sys_rst_in // [RULE_09]
      |=> ms_out == $past(load_ms_in) && days_out == $past(load_days_in))
      else $error("run-time clock load not taken");
   rtc_tick_gap_a: assert property (tick_out |=> !tick_out [*8]) // [RULE_13]
      else $error("millisecond ticks too close");
   rtc_ms_step_a: assert property (tick_out && !$past(load_in) // [RULE_13]
      && $past(ms_out) != MS_PER_DAY - 32'h1 |-> ms_out == $past(ms_out) + 32'h1)
      else $error("millisecond count did not step");
   rtc_day_roll_a: assert property (tick_out && !$past(load_in) // [RULE_13]
      && $past(ms_out) == MS_PER_DAY - 32'h1 |-> ms_out == '0
      && days_out == $past(days_out) + 32'h1)
      else $error("day rollover wrong");
endmodule

/* fault_peak_logger_brownout.sv */
// Health logger: fault entries, rail peaks, reset count, flash commit engine
// Operation
// RULE_01 - Log faults, reset count, per-rail peaks
// RULE_02 - New peak opens 30 s window, commit maximum
// RULE_03 - Logging disable keeps data in SRAM only
// RULE_04 - Several fault entries kept, host readable
// RULE_05 - Entry holds rail, kind, time, last voltage
// RULE_06 - Reset count in flash, host clears
// RULE_07 - Brownout mode writes flash only at power-down
// RULE_08 - Clock persists in brownout mode, else zero
// RULE_09 - Host may overwrite run-time clock
// RULE_10 - Flag brownout when supply below 2.9 V
// RULE_11 - Brownout mode accumulates, dumps all at brownout
// RULE_12 - Host enables brownout mode, default off
// RULE_13 - Clock is 32-bit milliseconds plus days
// RULE_14 - Each entry stamped from run-time clock
// RULE_15 - Faults during flash write held, committed later
`timescale 1ns/1ps
module fault_peak_logger_brownout
   import fault_log_pkg::*;
#(
   parameter int RAILS = RAILS_DEF,
   parameter int FAULTS = FAULTS_DEF,
   parameter int MS_CYCLES = MS_CYCLES_DEF,
   parameter int PEAK_HOLD_MS = PEAK_HOLD_MS_DEF
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic log_disable_in,
   input wire logic brownout_en_in,
   input wire logic brownout_in,
   input wire logic fault_valid_in,
   input wire logic [RAIL_W-1:0] fault_rail_in,
   input wire logic [KIND_W-1:0] fault_kind_in,
   input wire logic meas_valid_in,
   input wire logic [RAIL_W-1:0] meas_rail_in,
   input wire logic [VOLT_W-1:0] meas_value_in,
   input wire logic nvm_wr_ack_in,
   input wire logic [DATA_W-1:0] nvm_resets_in,
   input wire logic [DATA_W-1:0] nvm_rtc_ms_in,
   input wire logic [DATA_W-1:0] nvm_rtc_days_in,
   input wire logic host_clr_resets_in,
   input wire logic host_rtc_wr_in,
   input wire logic [DATA_W-1:0] host_rtc_ms_in,
   input wire logic [DATA_W-1:0] host_rtc_days_in,
   input wire logic rd_req_in,
   input wire logic [$clog2(FAULTS)-1:0] rd_idx_in,
   output nvm_wr_s nvm_wr_out,
   output logic [DATA_W-1:0] reset_cnt_out,
   output logic [DATA_W-1:0] rtc_ms_out,
   output logic [DATA_W-1:0] rtc_days_out,
   output logic brownout_flag_out,
   output logic dump_busy_out,
   output logic [$clog2(FAULTS):0] log_count_out,
   output logic fault_lost_out,
   output logic rd_valid_out,
   output fault_entry_s rd_entry_out
);
   localparam int FAW = $clog2(FAULTS);

   generate
      if (RAILS < 1 || RAILS > NVM_PEAK_ROOM || RAILS > (1 << RAIL_W)) begin : g_bad_rails
         $error("RAILS out of range");
      end
      if (FAULTS < 2 || (1 << FAW) != FAULTS || 2 * FAULTS > NVM_FAULT_ROOM) begin : g_bad_flt
         $error("FAULTS must be a power of two that fits the flash map");
      end
      if (PEAK_HOLD_MS < 2 || PEAK_HOLD_MS > 65535) begin : g_bad_hold
         $error("PEAK_HOLD_MS out of range");
      end
   endgenerate

   localparam logic [FAW:0] FAULT_FULL = (FAW + 1)'(FAULTS);

   // Restore from flash on the first cycle after reset release
   logic boot_q;
   logic bo_q;
   logic dump_q;
   logic [1:0] dump_rtc_q;
   logic resets_dirty_q;
   logic [RAILS-1:0] peak_pend_q;
   logic [FAW-1:0] wr_ptr_q;
   logic [FAW-1:0] cm_ptr_q;
   logic [FAW:0] pend_cnt_q;
   eng_e state_q;
   logic second_q;
   logic flt_q;
   logic ms_tick;
   logic [RAIL_W-1:0] peak_sel;
   fault_entry_s new_entry;
   fault_entry_s cm_entry;

   wire [RAILS-1:0][VOLT_W-1:0] peak_w;
   wire [RAILS-1:0][VOLT_W-1:0] last_v_w;
   wire [RAILS-1:0] peak_exp;

   // Power-down detection: level from the supply comparator
   wire bo_rise = brownout_in && !bo_q;
   wire dump_start = brownout_en_in && !log_disable_in && bo_rise && !dump_q; // [RULE_11]

   // Engine may write only when logging is on and, in brownout mode, only while dumping
   wire eng_idle = state_q == ENG_IDLE;
   wire eng_allow = !log_disable_in && (!brownout_en_in || dump_q); // [RULE_03] [RULE_07]
   wire rtc_busy = |dump_rtc_q;
   wire job_resets = eng_idle && eng_allow && resets_dirty_q;
   wire job_rtc_ms = eng_idle && eng_allow && !resets_dirty_q && dump_rtc_q[0];
   wire job_rtc_days = eng_idle && eng_allow && !resets_dirty_q && !dump_rtc_q[0]
      && dump_rtc_q[1];
   wire job_fault = eng_idle && eng_allow && !resets_dirty_q && !rtc_busy
      && pend_cnt_q != '0;
   wire job_peak = eng_idle && eng_allow && !resets_dirty_q && !rtc_busy
      && pend_cnt_q == '0 && |peak_pend_q;
   wire dump_done = eng_idle && eng_allow && dump_q && !resets_dirty_q && !rtc_busy
      && pend_cnt_q == '0 && !(|peak_pend_q);
   wire job_word = job_resets || job_rtc_ms || job_rtc_days || job_peak;

   wire [ADDR_W-1:0] job_addr = job_resets ? NVM_RESETS :
      job_rtc_ms ? NVM_RTC_MS :
      job_rtc_days ? NVM_RTC_DAYS :
      NVM_PEAK_BASE + ADDR_W'(peak_sel);
   wire [DATA_W-1:0] job_data = job_resets ? reset_cnt_out :
      job_rtc_ms ? rtc_ms_out :
      job_rtc_days ? rtc_days_out :
      DATA_W'(peak_w[peak_sel]);
   wire [RAILS-1:0] peak_clr = job_peak ? (RAILS'(1) << peak_sel) : '0;

   // Fault capture into SRAM; newest dropped when every slot awaits commit
   wire commit_done = state_q == ENG_WAIT && nvm_wr_ack_in && flt_q && !second_q;
   wire flush = log_disable_in && eng_idle; // [RULE_03]
   wire fault_acc = fault_valid_in && (flush || pend_cnt_q != FAULT_FULL); // [RULE_15]
   wire [FAW-1:0] wr_ptr_d = fault_acc ? wr_ptr_q + 1'b1 : wr_ptr_q;
   wire [ADDR_W-1:0] flt_addr = NVM_FAULT_BASE + ADDR_W'({cm_ptr_q, 1'b0});

   assign new_entry.rail = fault_rail_in; // [RULE_05]
   assign new_entry.kind = fault_kind_in;
   assign new_entry.volt = last_v_w[fault_rail_in];
   assign new_entry.days = rtc_days_out[DAYS_KEEP_W-1:0]; // [RULE_14]
   assign new_entry.ms = rtc_ms_out;

   always_comb begin
      peak_sel = '0;
      for (int i = RAILS - 1; i >= 0; i--) begin
         if (peak_pend_q[i]) begin
            peak_sel = RAIL_W'(i);
         end
      end
   end

   // Per-rail peak tracking with a hold window counted in milliseconds
   generate
      for (genvar r = 0; r < RAILS; r++) begin : g_rail
         logic [VOLT_W-1:0] pk_q;
         logic [VOLT_W-1:0] lv_q;
         logic act_q;
         logic [15:0] cnt_q;
         wire hit = meas_valid_in && meas_rail_in == RAIL_W'(r);
         wire higher = hit && meas_value_in > pk_q;
         wire expire = act_q && ms_tick && cnt_q == 16'(PEAK_HOLD_MS - 1);
         assign peak_w[r] = pk_q;
         assign last_v_w[r] = lv_q;
         assign peak_exp[r] = expire;
         always_ff @(posedge mclk_in) begin
            if (sys_rst_in) begin
               pk_q <= PEAK_RST;
               lv_q <= PEAK_RST;
               act_q <= 1'b0;
               cnt_q <= '0;
            end else begin
               lv_q <= hit ? meas_value_in : lv_q;
               pk_q <= higher ? meas_value_in : pk_q; // [RULE_02]
               if (higher && !act_q) begin
                  act_q <= 1'b1;
                  cnt_q <= '0;
               end else if (expire) begin
                  act_q <= 1'b0;
               end else if (act_q && ms_tick) begin
                  cnt_q <= cnt_q + 16'h1;
               end
            end
         end
      end
   endgenerate

   // Bookkeeping flags; a new set wins over a clear in the same cycle
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         boot_q <= 1'b1;
         bo_q <= 1'b0;
         brownout_flag_out <= 1'b0;
         dump_q <= 1'b0;
         dump_rtc_q <= '0;
         resets_dirty_q <= 1'b0;
         reset_cnt_out <= RESET_CNT_RST;
         peak_pend_q <= '0;
      end else begin
         boot_q <= 1'b0;
         bo_q <= brownout_in;
         brownout_flag_out <= brownout_flag_out || bo_rise; // [RULE_10]
         dump_q <= dump_start || (dump_q && !dump_done); // [RULE_11]
         dump_rtc_q <= dump_start ? 2'b11 :
            {dump_rtc_q[1] && !job_rtc_days, dump_rtc_q[0] && !job_rtc_ms}; // [RULE_07]
         resets_dirty_q <= (resets_dirty_q && !job_resets) || boot_q
            || host_clr_resets_in; // [RULE_06]
         if (host_clr_resets_in) begin
            reset_cnt_out <= RESET_CNT_RST; // [RULE_06]
         end else if (boot_q) begin
            reset_cnt_out <= nvm_resets_in + 32'h1; // [RULE_01]
         end
         peak_pend_q <= (peak_pend_q & ~peak_clr) | peak_exp
            | (dump_start ? {RAILS{1'b1}} : '0); // [RULE_02]
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         wr_ptr_q <= '0;
         cm_ptr_q <= '0;
         pend_cnt_q <= '0;
         log_count_out <= '0;
         fault_lost_out <= 1'b0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         if (flush) begin
            cm_ptr_q <= wr_ptr_d;
            pend_cnt_q <= '0;
         end else begin
            cm_ptr_q <= commit_done ? cm_ptr_q + 1'b1 : cm_ptr_q;
            pend_cnt_q <= pend_cnt_q + (FAW + 1)'(fault_acc)
               - (FAW + 1)'(commit_done); // [RULE_15]
         end
         if (fault_acc && log_count_out != FAULT_FULL) begin
            log_count_out <= log_count_out + 1'b1; // [RULE_04]
         end
         fault_lost_out <= fault_lost_out || (fault_valid_in && !fault_acc);
      end
   end

   // Flash commit engine: request held until the flash acknowledges each word
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         state_q <= ENG_IDLE;
         nvm_wr_out <= '0;
         second_q <= 1'b0;
         flt_q <= 1'b0;
      end else begin
         case (state_q)
            ENG_IDLE: begin
               if (job_fault) begin
                  state_q <= ENG_FETCH;
               end else if (job_word) begin
                  nvm_wr_out.req <= 1'b1; // [RULE_01]
                  nvm_wr_out.addr <= job_addr;
                  nvm_wr_out.data <= job_data;
                  state_q <= ENG_WAIT;
               end
            end
            ENG_FETCH: begin
               state_q <= ENG_FLT;
            end
            ENG_FLT: begin
               nvm_wr_out.req <= 1'b1; // [RULE_04]
               nvm_wr_out.addr <= flt_addr;
               nvm_wr_out.data <= cm_entry[63:32];
               second_q <= 1'b1;
               flt_q <= 1'b1;
               state_q <= ENG_WAIT;
            end
            ENG_WAIT: begin
               if (nvm_wr_ack_in && second_q) begin
                  nvm_wr_out.addr <= flt_addr + 8'h01;
                  nvm_wr_out.data <= cm_entry.ms;
                  second_q <= 1'b0;
               end else if (nvm_wr_ack_in) begin
                  nvm_wr_out.req <= 1'b0;
                  flt_q <= 1'b0;
                  state_q <= ENG_IDLE;
               end
            end
            default: begin
               state_q <= ENG_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= rd_req_in; // [RULE_04]
      end
   end

   assign dump_busy_out = dump_q;

   // Clock restored from flash only when it is meant to span resets
   wire rtc_restore = boot_q && brownout_en_in; // [RULE_08]
   wire rtc_load = rtc_restore || host_rtc_wr_in; // [RULE_09]
   wire [DATA_W-1:0] rtc_ld_ms = host_rtc_wr_in ? host_rtc_ms_in : nvm_rtc_ms_in;
   wire [DATA_W-1:0] rtc_ld_days = host_rtc_wr_in ? host_rtc_days_in : nvm_rtc_days_in;

   run_time_clock #(.MS_CYCLES(MS_CYCLES)) u_rtc (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .load_in(rtc_load),
      .load_ms_in(rtc_ld_ms),
      .load_days_in(rtc_ld_days),
      .ms_out(rtc_ms_out),
      .days_out(rtc_days_out),
      .tick_out(ms_tick)
   );

   fault_log_ram #(.DEPTH(FAULTS), .AW(FAW)) u_ram (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .we_in(fault_acc),
      .waddr_in(wr_ptr_q),
      .wdata_in(new_entry),
      .raddr_a_in(cm_ptr_q),
      .rdata_a_out(cm_entry),
      .raddr_b_in(rd_idx_in),
      .rdata_b_out(rd_entry_out)
   );

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   sequence dump_trigger_s;
      brownout_en_in && !log_disable_in && bo_rise && !dump_q;
   endsequence
   sequence dump_held_s;
      dump_q && dump_rtc_q == 2'b11;
   endsequence

   brownout_flag_a: assert property (bo_rise |=> brownout_flag_out [*3]) // [RULE_10]
      else $error("brownout not flagged");
   dump_start_a: assert property (dump_trigger_s |=> dump_held_s) // [RULE_11]
      else $error("brownout dump not started");
   no_wr_disabled_a: assert property ($rose(nvm_wr_out.req) |-> $past(!log_disable_in)) // [RULE_03]
      else $error("flash write while logging disabled");
   bo_mode_quiet_a: assert property ($rose(nvm_wr_out.req) // [RULE_07]
      |-> $past(!brownout_en_in || dump_q))
      else $error("flash write in brownout mode outside dump");
   req_hold_a: assert property (nvm_wr_out.req && !nvm_wr_ack_in // [RULE_01]
      |=> nvm_wr_out.req && $stable(nvm_wr_out.addr))
      else $error("flash request dropped before ack");
   reset_clear_a: assert property (host_clr_resets_in |=> reset_cnt_out == '0 // [RULE_06]
      && resets_dirty_q)
      else $error("reset count not cleared");
   boot_count_a: assert property (boot_q && !sys_rst_in && !host_clr_resets_in // [RULE_01]
      |=> reset_cnt_out == $past(nvm_resets_in) + 32'h1)
      else $error("reset count not advanced at start");
   rtc_zero_a: assert property (boot_q && !brownout_en_in && !host_rtc_wr_in // [RULE_08]
      |=> rtc_ms_out == '0 && rtc_days_out == '0)
      else $error("run-time clock not restarted");
   peak_track_a: assert property (meas_valid_in && meas_value_in > peak_w[meas_rail_in] // [RULE_02]
      |=> peak_w[$past(meas_rail_in)] == $past(meas_value_in))
      else $error("peak not tracked");
   fault_hold_a: assert property (fault_acc && !commit_done && !flush // [RULE_15]
      |=> pend_cnt_q == $past(pend_cnt_q) + 1'b1)
      else $error("fault not held for commit");
endmodule

/* flash_model.sv */
// Flash write port model: acknowledges each word after a settable delay
`timescale 1ns/1ps
module flash_model
   import fault_log_pkg::*;
(
   input wire logic mclk_in,
   input wire logic clr_in,
   input wire logic [7:0] dly_in,
   input wire nvm_wr_s wr_in,
   output logic ack_out
);
   logic [DATA_W-1:0] mem [0:255];
   int unsigned n_wr;
   logic [7:0] cnt_q;
   initial ack_out = 1'h0;
   always @(posedge mclk_in) begin
      ack_out <= 1'h0;
      if (clr_in) begin
         cnt_q <= 8'h00;
         n_wr <= 0;
         for (int i = 0; i < 256; i++) begin
            mem[i] <= 32'hdead_beef;
         end
      end else if (wr_in.req && !ack_out) begin
         // Slow flash: the device must hold the word until the ack edge
         if (cnt_q >= dly_in) begin
            ack_out <= 1'h1;
            cnt_q <= 8'h00;
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
      if (wr_in.req && ack_out && !clr_in) begin
         mem[wr_in.addr] <= wr_in.data;
         n_wr <= n_wr + 1;
      end
   end
endmodule

/* tb_top.sv */
// Self-checking bench for the fault and peak logger
`timescale 1ns/1ps
module tb_top;
   import fault_log_pkg::*;
   logic mclk_in = 1'h0, sys_rst_in = 1'h1, log_dis = 1'h0, bo_en = 1'h0, bo = 1'h0;
   logic f_v = 1'h0, m_v = 1'h0, ack, clr_r = 1'h1, h_clr = 1'h0, h_wr = 1'h0, rd_req = 1'h0;
   logic [3:0] f_r = 4'h0, f_k = 4'h0, m_r = 4'h0;
   logic [11:0] m_val = 12'h000;
   logic [2:0] rd_idx = 3'h0;
   logic [7:0] dly = 8'h00;
   logic [31:0] nv_rst = 32'h0000_0041, nv_ms = 32'h0000_1000, nv_dy = 32'h0000_0005;
   logic [31:0] h_ms = 32'h0, h_dy = 32'h0;
   nvm_wr_s wr;
   logic [31:0] reset_cnt_out, rtc_ms_out, rtc_days_out;
   logic brownout_flag_out, dump_busy_out, fault_lost_out, rd_valid_out;
   logic [3:0] log_count_out;
   fault_entry_s rd_entry_out;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;

   always #10 mclk_in = ~mclk_in;

   fault_peak_logger_brownout #(.RAILS(10), .FAULTS(8), .MS_CYCLES(10), .PEAK_HOLD_MS(4))
   u_fault_peak_logger_brownout (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .log_disable_in(log_dis),
      .brownout_en_in(bo_en), .brownout_in(bo), .fault_valid_in(f_v), .fault_rail_in(f_r),
      .fault_kind_in(f_k), .meas_valid_in(m_v), .meas_rail_in(m_r), .meas_value_in(m_val),
      .nvm_wr_ack_in(ack), .nvm_resets_in(nv_rst), .nvm_rtc_ms_in(nv_ms),
      .nvm_rtc_days_in(nv_dy), .host_clr_resets_in(h_clr), .host_rtc_wr_in(h_wr),
      .host_rtc_ms_in(h_ms), .host_rtc_days_in(h_dy), .rd_req_in(rd_req), .rd_idx_in(rd_idx),
      .nvm_wr_out(wr), .reset_cnt_out(reset_cnt_out), .rtc_ms_out(rtc_ms_out),
      .rtc_days_out(rtc_days_out), .brownout_flag_out(brownout_flag_out),
      .dump_busy_out(dump_busy_out), .log_count_out(log_count_out),
      .fault_lost_out(fault_lost_out), .rd_valid_out(rd_valid_out), .rd_entry_out(rd_entry_out));

   flash_model u_flash (.mclk_in(mclk_in), .clr_in(clr_r), .dly_in(dly), .wr_in(wr),
      .ack_out(ack));

   task automatic test_done();
      if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard, well above the expected run length
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_mem(input logic [7:0] a, input logic [31:0] e);
      int n;
      n = 0;
      while (u_flash.mem[a] !== e && n < 3000) begin
         @(posedge mclk_in);
         n++;
      end
      chk(u_flash.mem[a], e);
   endtask

   task automatic do_reset(input logic en);
      @(posedge mclk_in);
      sys_rst_in <= 1'h1;
      clr_r <= 1'h1;
      bo_en <= en;
      bo <= 1'h0;
      repeat (6) @(posedge mclk_in);
      sys_rst_in <= 1'h0;
      clr_r <= 1'h0;
      @(posedge mclk_in);
      @(negedge mclk_in);
   endtask

   task automatic meas(input logic [3:0] r, input logic [11:0] v);
      @(posedge mclk_in);
      m_v <= 1'h1;
      m_r <= r;
      m_val <= v;
      @(posedge mclk_in);
      m_v <= 1'h0;
   endtask

   task automatic fault(input logic [3:0] r, input logic [3:0] k, output logic [31:0] ms,
                        output logic [11:0] dy);
      @(posedge mclk_in);
      f_v <= 1'h1;
      f_r <= r;
      f_k <= k;
      @(negedge mclk_in);
      ms = rtc_ms_out;
      dy = rtc_days_out[11:0];
      @(posedge mclk_in);
      f_v <= 1'h0;
   endtask

   task automatic read_chk(input logic [2:0] i, input fault_entry_s e);
      @(posedge mclk_in);
      rd_req <= 1'h1;
      rd_idx <= i;
      @(posedge mclk_in);
      rd_req <= 1'h0;
      @(negedge mclk_in);
      chk(rd_valid_out, 64'h1);
      chk(rd_entry_out, e);
   endtask

   task automatic t_boot();
      do_reset(1'h0);
      chk(reset_cnt_out, 64'h42);
      chk(rtc_days_out, 64'h0);
      chk(rtc_ms_out < 32'h4, 64'h1);
      wait_mem(8'h00, 32'h42);
   endtask

   task automatic t_clock();
      int n;
      @(posedge mclk_in);
      h_wr <= 1'h1;
      h_ms <= MS_PER_DAY - 32'h2;
      h_dy <= 32'h0000_0abc;
      @(posedge mclk_in);
      h_wr <= 1'h0;
      @(negedge mclk_in);
      chk(rtc_ms_out, MS_PER_DAY - 32'h2);
      chk(rtc_days_out, 64'habc);
      n = 0;
      while (rtc_days_out === 32'h0000_0abc && n < 60) begin
         @(negedge mclk_in);
         n++;
      end
      chk(rtc_days_out, 64'habd);
      chk(rtc_ms_out, 64'h0);
   endtask

   task automatic t_fault();
      logic [31:0] ma, mb;
      logic [11:0] da, db;
      dly <= 8'h0c;
      meas(4'h3, 12'h123);
      meas(4'h4, 12'h0aa);
      fault(4'h3, 4'h5, ma, da);
      repeat (6) @(posedge mclk_in);
      // Second fault lands while the first is still being written
      fault(4'h4, 4'h6, mb, db);
      @(negedge mclk_in);
      chk(log_count_out, 64'h2);
      chk(fault_lost_out, 64'h0);
      read_chk(3'h0, {4'h3, 4'h5, 12'h123, da, ma});
      read_chk(3'h1, {4'h4, 4'h6, 12'h0aa, db, mb});
      wait_mem(8'h20, {4'h3, 4'h5, 12'h123, da});
      wait_mem(8'h21, ma);
      wait_mem(8'h22, {4'h4, 4'h6, 12'h0aa, db});
      wait_mem(8'h23, mb);
   endtask

   task automatic t_peak();
      dly <= 8'h00;
      meas(4'h2, 12'h100);
      meas(4'h2, 12'h200);
      meas(4'h2, 12'h150);
      wait_mem(8'h06, 32'h200);
   endtask

   task automatic t_disable();
      int unsigned n;
      logic [31:0] ms;
      logic [11:0] dy;
      log_dis <= 1'h1;
      n = u_flash.n_wr;
      meas(4'h1, 12'h3ff);
      fault(4'h1, 4'h2, ms, dy);
      repeat (200) @(posedge mclk_in);
      chk(u_flash.n_wr, n);
      chk(log_count_out, 64'h3);
      log_dis <= 1'h0;
   endtask

   task automatic t_clear();
      @(posedge mclk_in);
      h_clr <= 1'h1;
      @(posedge mclk_in);
      h_clr <= 1'h0;
      @(negedge mclk_in);
      chk(reset_cnt_out, 64'h0);
      wait_mem(8'h00, 32'h0);
   endtask

   task automatic t_brownout();
      int unsigned n;
      logic [31:0] ms;
      logic [11:0] dy;
      do_reset(1'h1);
      chk(rtc_days_out, 64'h5);
      chk(rtc_ms_out >= 32'h1000 && rtc_ms_out < 32'h1004, 64'h1);
      n = u_flash.n_wr;
      meas(4'h5, 12'h300);
      fault(4'h5, 4'h7, ms, dy);
      repeat (300) @(posedge mclk_in);
      chk(u_flash.n_wr, n);
      @(posedge mclk_in);
      bo <= 1'h1;
      repeat (2) @(posedge mclk_in);
      @(negedge mclk_in);
      chk(brownout_flag_out, 64'h1);
      chk(dump_busy_out, 64'h1);
      n = 0;
      while (dump_busy_out !== 1'h0 && n < 2000) begin
         @(negedge mclk_in);
         n++;
      end
      chk(dump_busy_out, 64'h0);
      chk(u_flash.mem[8'h00], 64'h42);
      chk(u_flash.mem[8'h02], 64'h5);
      chk(u_flash.mem[8'h09], 64'h300);
      chk(u_flash.mem[8'h20], {4'h5, 4'h7, 12'h300, dy});
      chk(u_flash.mem[8'h21], ms);
   endtask

   initial begin
      t_boot();
      t_clock();
      t_fault();
      t_peak();
      t_disable();
      t_clear();
      t_brownout();
      test_done();
   end
endmodule
